/* inc/sacs_cfg.svh */
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef SACS_CFG_SVH
`define SACS_CFG_SVH
`define SACS_CTRL_OFS      8'h00
`define SACS_STATUS_OFS    8'h04
`define SACS_RESULT_OFS    8'h08
`define SACS_COUNT_OFS     8'h0c
`define SACS_CTRL_REFPD    0
`define SACS_CTRL_RST      32'h0000_0000
`define SACS_ST_STATE_LSB  0
`define SACS_ST_SHUT       3
`define SACS_ST_EOC        4
`define SACS_ST_SETTLED    5
`define SACS_ST_TRUST      6
`define SACS_ST_ACQSHORT   7
`define SACS_CLK_NS        100
`define SACS_T_CONV_NS     4700
`define SACS_T_ACQ_NS      1100
`define SACS_T_WAKE_NS     10000000
`define SACS_CONV_MAX_CYC  (`SACS_T_CONV_NS / `SACS_CLK_NS)
`define SACS_ACQ_MIN_CYC   ((`SACS_T_ACQ_NS + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`define SACS_WAKE_CYC      ((`SACS_T_WAKE_NS + `SACS_CLK_NS - 1) / `SACS_CLK_NS)
`define SACS_SAR_DIV       3
`endif

/* inc/sacs_pkg.sv */
// types of the conversion sequencer
`default_nettype none
package sacs_pkg;
    typedef enum logic [2:0] {
        sacs_idle,
        sacs_acq,
        sacs_conv,
        sacs_done,
        sacs_read
    } sacs_state_e;
endpackage
`default_nettype wire

/* src/sacs_top.sv */
// conversion sequencer with strobe/select host port and axi4-lite registers
// Behaviour
// (R1) 14-bit result by successive approximation on a held sample.
// (R2) second strobe fall opens the hold switch and starts conversion.
// (R3) host gives at least 1.1us acquisition between first and second fall.
// (R4) select low at second fall: standby afterwards, reference kept on.
// (R5) select high at second fall: shutdown afterwards, reference powered down.
// (R6) conversion finishes within 4.7us from hold to end-of-conversion fall.
// (R7) conversion clock is made internally, no host clock needed.
// (R8) first fall with select low powers up and enters acquisition.
// (R9) strobe fall with select high is ignored when starting.
// (R10) host waits 10ms for reference settling after shutdown wake.
// (R11) host runs one dummy conversion after shutdown wake.
// (R12) standby: fall with select low starts acquisition at once.
// (R13) shutdown: fall with select low wakes reference and acquires.
// (R14) host drops strobe again after completion to read the result.
// (R15) host sets reference power-down high with an external reference.
// (R16) end-of-conversion driven low when result is valid.
// (R17) result bus undriven during acquisition and conversion.
// (R18) strobe rise after read releases the bus; wait for next cycle.
// (R19) byte-wide: upper byte select high gives msb, low gives lsb.
// (R20) host counts strobe falls as acquire, convert, read.
`include "sacs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sacs_top
    import sacs_pkg::*;
#(
    parameter int          RES_W     = 14,
    parameter bit          BYTE_WIDE = 1'b0,
    parameter int unsigned WAKE_CYC  = `SACS_WAKE_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic              cs_n,
    input  wire logic              rd_conv,
    input  wire logic              upper_byte_select,
    input  wire logic              conv_reset,
    input  wire logic              comp_high,
    output logic [RES_W-1:0]       dac_code,
    output logic                   hold,
    output logic                   ref_on,
    output logic                   eoc_n,
    output logic [RES_W-1:0]       result_bus,
    output logic                   result_oe,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam logic [1:0] DIV_LAST = 2'(`SACS_SAR_DIV - 1);
    localparam logic [5:0] CONV_MAX = 6'(`SACS_CONV_MAX_CYC);
    localparam logic [3:0] ACQ_MIN  = 4'(`SACS_ACQ_MIN_CYC);

    sacs_state_e       state;
    logic              cs_q;
    logic              cs_fall;
    logic              shut_mode;
    logic              ref_pd;
    logic [RES_W-1:0]  result;
    logic [3:0]        bit_idx;
    logic [1:0]        div;
    logic [5:0]        conv_cyc;
    logic [3:0]        acq_cyc;
    logic              acq_short;
    logic [16:0]       wake_cnt;
    logic              settled;
    logic              trust;
    logic [31:0]       conv_count;
    logic [RES_W-1:0]  next_code;
    logic              sar_last;

    assign cs_fall   = cs_q & ~cs_n;
    assign sar_last  = (state == sacs_conv) && (div == DIV_LAST) && (bit_idx == 4'h0);
    assign next_code = comp_high ? dac_code : (dac_code & ~(RES_W'(1) << bit_idx));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cs_q <= 1'b1;
        end else if (ce) begin
            cs_q <= cs_n;
        end
    end

    // strobe-driven sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= sacs_idle;
            shut_mode <= 1'b1;
            hold      <= 1'b0;
        end else if (ce) begin
            if (conv_reset && cs_n) begin
                state <= sacs_idle;
                hold  <= 1'b0;
            end else begin
                unique case (state)
                    sacs_idle: begin
                        if (cs_fall && !rd_conv) begin // [R8] [R9] [R12] [R13]
                            state <= sacs_acq;
                        end
                    end
                    sacs_acq: begin
                        if (cs_fall) begin // [R2]
                            state     <= sacs_conv;
                            hold      <= 1'b1;
                            shut_mode <= rd_conv; // [R4] [R5]
                        end
                    end
                    sacs_conv: begin
                        if (sar_last) begin
                            state <= sacs_done;
                            hold  <= 1'b0;
                        end
                    end
                    sacs_done: begin
                        if (cs_fall && rd_conv) begin
                            state <= sacs_read;
                        end
                    end
                    sacs_read: begin
                        if (cs_n) begin // [R18]
                            state <= sacs_idle;
                        end
                    end
                endcase
            end
        end
    end

    // internal conversion clock and successive approximation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_code <= '0;
            bit_idx  <= 4'h0;
            div      <= 2'h0;
            result   <= '0;
        end else if (ce) begin
            if (state == sacs_acq && cs_fall) begin
                dac_code <= RES_W'(1) << (RES_W - 1);
                bit_idx  <= 4'(RES_W - 1);
                div      <= 2'h0;
            end else if (state == sacs_conv) begin // [R7]
                div <= (div == DIV_LAST) ? 2'h0 : div + 2'h1;
                if (div == DIV_LAST) begin // [R1]
                    if (bit_idx == 4'h0) begin
                        dac_code <= next_code;
                        result   <= next_code;
                    end else begin
                        dac_code <= next_code | (RES_W'(1) << (bit_idx - 4'h1));
                        bit_idx  <= bit_idx - 4'h1;
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cyc <= 6'h0;
        end else if (ce) begin
            conv_cyc <= (state == sacs_conv) ? conv_cyc + 6'h1 : 6'h0;
        end
    end

    // end of conversion flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc_n <= 1'b1;
        end else if (ce) begin
            if (conv_reset && cs_n) begin
                eoc_n <= 1'b1;
            end else if (sar_last) begin
                eoc_n <= 1'b0; // [R16] [R6]
            end else if (state == sacs_read && cs_n) begin
                eoc_n <= 1'b1;
            end
        end
    end

    // result bus, driven only in the read phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_bus <= '0;
            result_oe  <= 1'b0;
        end else if (ce) begin
            result_oe <= (state == sacs_done && cs_fall && rd_conv) || (state == sacs_read && !cs_n); // [R17] [R18]
            if (!BYTE_WIDE) begin
                result_bus <= result;
            end else if (upper_byte_select) begin // [R19]
                result_bus <= RES_W'(result >> 8);
            end else begin
                result_bus <= RES_W'(result[7:0]);
            end
        end
    end

    // reference power, acquisition length and wake tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_on    <= 1'b0;
            acq_cyc   <= 4'h0;
            acq_short <= 1'b0;
            wake_cnt  <= 17'h0;
            settled   <= 1'b0;
            trust     <= 1'b0;
        end else if (ce) begin
            if (state == sacs_idle && cs_fall && !rd_conv) begin
                ref_on <= ~ref_pd; // [R12] [R13]
                if (shut_mode) begin
                    trust    <= 1'b0;
                    settled  <= 1'b0;
                    wake_cnt <= 17'h0;
                end
            end else if (sar_last && shut_mode) begin
                ref_on <= 1'b0; // [R5]
            end else if (ref_pd) begin
                ref_on <= 1'b0;
            end
            if (!settled && ref_on) begin
                wake_cnt <= wake_cnt + 17'h1;
                settled  <= (wake_cnt >= 17'(WAKE_CYC - 1));
            end
            if (state == sacs_read && cs_n) begin
                trust <= 1'b1;
            end
            if (conv_reset && cs_n) begin
                trust <= 1'b1;
            end
            if (state == sacs_acq) begin
                acq_cyc <= (acq_cyc == 4'hf) ? acq_cyc : acq_cyc + 4'h1;
                if (cs_fall) begin
                    acq_short <= (acq_cyc < ACQ_MIN);
                end
            end else begin
                acq_cyc <= 4'h0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_count <= 32'h0;
        end else if (ce && sar_last) begin
            conv_count <= conv_count + 32'h1;
        end
    end

    function automatic logic reg_known(input logic [7:0] a);
        return a == `SACS_CTRL_OFS || a == `SACS_STATUS_OFS || a == `SACS_RESULT_OFS || a == `SACS_COUNT_OFS;
    endfunction

    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            ref_pd        <= 1'(`SACS_CTRL_RST);
        end else if (ce) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end else if (!s_axi_bvalid && !s_axi_awready && s_axi_awvalid && s_axi_wvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= reg_known(s_axi_awaddr) ? 2'b00 : 2'b10;
                if (s_axi_awaddr == `SACS_CTRL_OFS && s_axi_wstrb[0]) begin
                    ref_pd <= s_axi_wdata[`SACS_CTRL_REFPD]; // [R15]
                end
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else if (ce) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= reg_known(s_axi_araddr) ? 2'b00 : 2'b10;
                unique case (s_axi_araddr)
                    `SACS_CTRL_OFS: begin
                        s_axi_rdata <= 32'(ref_pd);
                    end
                    `SACS_STATUS_OFS: begin
                        s_axi_rdata <= 32'({acq_short, trust, settled, ~eoc_n, shut_mode, 3'(state)});
                    end
                    `SACS_RESULT_OFS: begin
                        s_axi_rdata <= 32'(result);
                    end
                    `SACS_COUNT_OFS: begin
                        s_axi_rdata <= conv_count;
                    end
                    default: begin
                        s_axi_rdata <= 32'h0;
                    end
                endcase
            end
        end
    end

    sequence s_conv_start;
        ce && state == sacs_acq && cs_fall;
    endsequence

    sequence s_result_ready;
        ce && sar_last;
    endsequence

    a_hold_at_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
        s_conv_start |=> hold && state == sacs_conv && shut_mode == $past(rd_conv))
        else $error("hold not taken at second strobe fall");
    a_conv_bound: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
        state == sacs_conv |-> conv_cyc < CONV_MAX)
        else $error("conversion longer than allowed");
    a_eoc_result: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
        s_result_ready |=> !eoc_n && state == sacs_done && result == dac_code)
        else $error("end of conversion not flagged with result");
    a_sar_settle: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
        s_conv_start ##1 (state == sacs_conv && ce) [*8] |-> !sar_last && eoc_n)
        else $error("approximation ended too early");
    a_bus_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
        (state == sacs_acq || state == sacs_conv) |-> !result_oe)
        else $error("result bus driven outside read");
    a_bus_release: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
        ce && state == sacs_read && cs_n |=> !result_oe && eoc_n && state == sacs_idle)
        else $error("bus not released on strobe rise");
    a_shut_ref: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        s_result_ready and shut_mode |=> !ref_on)
        else $error("reference left on in shutdown");
    a_stby_ref: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        s_result_ready and !shut_mode and ref_on and !ref_pd |=> ref_on)
        else $error("reference dropped in standby");
    a_start_acq: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        ce && state == sacs_idle && cs_fall && !rd_conv && !conv_reset |=> state == sacs_acq && ref_on == !$past(ref_pd))
        else $error("acquisition not entered");
    a_ignore_high: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
        ce && state == sacs_idle && cs_fall && rd_conv |=> state == sacs_idle)
        else $error("start accepted with select high");
    a_byte_pick: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
        BYTE_WIDE && ce && upper_byte_select |=> result_bus == RES_W'($past(result) >> 8))
        else $error("upper byte not selected");
endmodule
`default_nettype wire

/* verif/sacs_host_model.sv */
// host model driving the convert strobe and the read/convert select
`timescale 1ns/1ps
`default_nettype none
module sacs_host_model #(
    parameter int ACQ_CYC  = 12,
    parameter int WAKE_CYC = 20
) (
    input  wire logic aclk,
    output logic      cs_n,
    output logic      rd_conv
);
    initial begin
        cs_n    = 1'h1;
        rd_conv = 1'h0;
    end
    task automatic fall(input logic rc);
        @(posedge aclk);
        cs_n    <= 1'h0;
        rd_conv <= rc;
    endtask
    task automatic lift();
        @(posedge aclk);
        cs_n <= 1'h1;
    endtask
    // first fall of a cycle, select low
    task automatic acquire();
        fall(1'h0);
        lift();
    endtask
    // acquisition interval kept above the minimum before the second fall
    task automatic convert(input logic rc);
        repeat (ACQ_CYC) @(posedge aclk);
        fall(rc);
        lift();
    endtask
    // reference settling after a wake from shutdown
    task automatic wake_wait();
        repeat (WAKE_CYC) @(posedge aclk);
    endtask
    task automatic read_start();
        fall(1'h1);
    endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sacs_cfg.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
    import sacs_pkg::*;
    typedef struct {logic [13:0] v; logic rc; logic [13:0] res; logic ref_after;} sacs_row_s;
    logic        aclk = 1'h0, aresetn = 1'h0, conv_reset = 1'h0, comp_high = 1'h0, upper_byte_select = 1'h0;
    logic [13:0] analog_input = 14'h0, dac_code, result_bus;
    logic        cs_n, rd_conv, hold, ref_on, eoc_n, result_oe;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          bad_count = 0, checks_done = 0, cyc = 0;
    localparam int WAKE_CYC = 20;
    logic        was_shut = 1'h1;
    sacs_row_s   rows [4] = '{'{14'h0000, 1'h0, 14'h0000, 1'h1}, '{14'h3fff, 1'h1, 14'h3fff, 1'h0},
                              '{14'h2a55, 1'h0, 14'h2a55, 1'h1}, '{14'h15aa, 1'h1, 14'h15aa, 1'h0}};

    always #50 aclk = ~aclk;
    // ideal comparator against the trial code
    always @(posedge aclk) comp_high <= (analog_input >= dac_code);
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end

    sacs_host_model #(.WAKE_CYC(WAKE_CYC)) host (.aclk(aclk), .cs_n(cs_n), .rd_conv(rd_conv));
    sacs_top #(.BYTE_WIDE(1'h1), .WAKE_CYC(WAKE_CYC)) dut (
        .aclk, .aresetn, .ce(1'h1), .cs_n, .rd_conv, .upper_byte_select, .conv_reset, .comp_high,
        .dac_code, .hold, .ref_on, .eoc_n, .result_bus, .result_oe,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic do_conv(input logic [13:0] v, input logic rc, input logic ref_after);
        int k;
        k = 0;
        analog_input <= v;
        host.acquire();
        @(posedge aclk);
        `CHK("ref_on acquire", 1'h1, ref_on)
        `CHK("oe acquire", 1'h0, result_oe)
        if (was_shut) begin
            host.wake_wait();
            axi_rd(`SACS_STATUS_OFS);
            `CHK("settled at start", 1'h1, d[5])
        end
        host.convert(rc);
        was_shut = rc;
        while (eoc_n !== 1'h0 && k < 60) begin
            @(posedge aclk);
            k++;
            if (k == 10) begin
                `CHK("hold", 1'h1, hold)
                `CHK("oe convert", 1'h0, result_oe)
            end
        end
        `CHK("eoc in time", 1'h1, k <= 48)
        `CHK("hold released", 1'h0, hold)
        `CHK("ref_on after", ref_after, ref_on)
    endtask
    task automatic do_read(input logic [13:0] res);
        host.read_start();
        repeat (2) @(posedge aclk);
        `CHK("oe read", 1'h1, result_oe)
        `CHK("result low", 14'(res[7:0]), result_bus)
        upper_byte_select <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("result high", 14'(res[13:8]), result_bus)
        upper_byte_select <= 1'h0;
        host.lift();
        repeat (2) @(posedge aclk);
        `CHK("oe released", 1'h0, result_oe)
        `CHK("eoc cleared", 1'h1, eoc_n)
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        `CHK("eoc reset", 1'h1, eoc_n)
        `CHK("oe reset", 1'h0, result_oe)
        aresetn <= 1'h1;
        axi_rd(`SACS_CTRL_OFS);
        `CHK("ctrl reset", 32'h0, d)
        axi_rd(`SACS_STATUS_OFS);
        `CHK("status reset", 8'h08, d[7:0] & 8'h9f)
        foreach (rows[i]) begin
            do_conv(rows[i].v, rows[i].rc, rows[i].ref_after);
            do_read(rows[i].res);
        end
        axi_rd(`SACS_COUNT_OFS);
        `CHK("count", 32'h4, d)
        axi_rd(`SACS_RESULT_OFS);
        `CHK("result reg", 32'h15aa, d)
        axi_rd(`SACS_STATUS_OFS);
        `CHK("status idle shut", 8'h08, d[7:0] & 8'h9f)
        // start with select high is ignored while shut down
        host.fall(1'h1);
        host.lift();
        repeat (2) @(posedge aclk);
        `CHK("ref_on ignored", 1'h0, ref_on)
        axi_rd(`SACS_STATUS_OFS);
        `CHK("state ignored", 3'h0, d[2:0])
        // dummy conversion after wake
        do_conv(14'h0fff, 1'h0, 1'h1);
        do_read(14'h0fff);
        axi_rd(`SACS_STATUS_OFS);
        `CHK("settled trust", 2'h3, d[6:5])
        // fall with select low while done is refused, then the reset pin
        do_conv(14'h0101, 1'h0, 1'h1);
        host.fall(1'h0);
        host.lift();
        repeat (2) @(posedge aclk);
        `CHK("eoc kept", 1'h0, eoc_n)
        `CHK("oe kept off", 1'h0, result_oe)
        conv_reset <= 1'h1;
        @(posedge aclk);
        conv_reset <= 1'h0;
        @(posedge aclk);
        `CHK("eoc after reset pin", 1'h1, eoc_n)
        do_conv(14'h2001, 1'h0, 1'h1);
        do_read(14'h2001);
        axi_wr(`SACS_CTRL_OFS, 32'h1);
        `CHK("ctrl bresp", 2'h0, r)
        repeat (2) @(posedge aclk);
        `CHK("ref_on forced off", 1'h0, ref_on)
        axi_rd(`SACS_CTRL_OFS);
        `CHK("ctrl readback", 32'h1, d)
        axi_wr(`SACS_CTRL_OFS, 32'h0);
        axi_wr(8'h40, 32'h1);
        `CHK("unmapped bresp", 2'h2, r)
        axi_rd(8'h44);
        `CHK("unmapped rresp", 2'h2, r)
        `CHK("unmapped rdata", 32'h0, d)
        // reset pulled in mid-conversion
        host.acquire();
        host.convert(1'h0);
        repeat (5) @(posedge aclk);
        `CHK("hold before reset", 1'h1, hold)
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        `CHK("hold after reset", 1'h0, hold)
        `CHK("eoc after reset", 1'h1, eoc_n)
        `CHK("ref_on after reset", 1'h0, ref_on)
        `CHK("oe after reset", 1'h0, result_oe)
        axi_rd(`SACS_STATUS_OFS);
        `CHK("status after reset", 8'h08, d[7:0] & 8'h9f)
        close_out();
    end
endmodule
`default_nettype wire
